// [src/fce_engine.sv]
// Purpose: spi command decoder and datapath of a serial nonvolatile memory
// Assumes: spi clock at most sys_clk/8, modes 0 and 3
// Notes: pins pass two flops; data sampled on sck rise, driven on fall
`timescale 1ns/100ps
module fce_engine
    import fce_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEFAULT,
    parameter logic [55:0] ID_MAKER = 56'h0101_0101_0101_01, // arbitrary value
    parameter logic [2:0] ID_FAMILY = 3'h1,                   // arbitrary value
    parameter logic [3:0] ID_DENSITY = 4'h1,                  // arbitrary value
    parameter logic ID_INRUSH = 1'b0,                         // arbitrary value
    parameter logic [2:0] ID_SUBTYPE = 3'h1,                  // arbitrary value
    parameter logic [1:0] ID_REVISION = 2'h0,                 // arbitrary value
    parameter logic ID_VOLTAGE = 1'b0,                        // arbitrary value
    parameter logic [1:0] ID_FREQ = 2'h1                      // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_si,
    input wire logic wp_n,
    output logic spi_so,
    output logic spi_so_oe,
    output logic [7:0] status_byte
);
    logic [3:0] pins_s;
    logic cs_n_s, sck_s, si_s, wp_n_s;
    logic sck_prev_reg, cs_prev_reg;
    fce_state_t state_reg, state_next, cmd_state;
    logic [2:0] bit_reg;
    logic [6:0] sh_reg;
    logic [1:0] abyte_reg;
    logic [15:0] ashift_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] op_reg;
    logic op_valid_reg, frame_wel_reg, halt_reg;
    logic wel_reg, ppe_reg;
    logic [1:0] bp_reg;
    logic [3:0] id_idx_reg;
    logic fetch_reg, fetch2_reg;
    logic [7:0] tx_reg;
    logic so_reg, oe_reg;
    logic [7:0] status_reg;
    logic [7:0] main_rdata, sect_rdata;

    // pin synchroniser, idle levels: wp high, cs high, sck and si low
    fce_sync #(.WIDTH(4), .RESET_VAL(4'b1100)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({wp_n, spi_cs_n, spi_sck, spi_si}),
        .sync_out(pins_s)
    );
    assign wp_n_s = pins_s[3];
    assign cs_n_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[0];

    // edges only count while selected, so mode 3 idle-high sck is harmless
    wire sck_rise = sck_s & ~sck_prev_reg & ~cs_n_s;
    wire sck_fall = ~sck_s & sck_prev_reg & ~cs_n_s;
    wire cs_rise = cs_n_s & ~cs_prev_reg;
    wire byte_done = sck_rise && (bit_reg == BIT_LAST);
    wire [7:0] rx_byte = {sh_reg, si_s};

    // opcode decode of the byte just received and of the held opcode
    wire cmd_addr = (rx_byte == OP_ARRAY_WRITE) || (rx_byte == OP_ARRAY_READ) ||
        (rx_byte == OP_FAST_READ) || (rx_byte == OP_SECTOR_WRITE) ||
        (rx_byte == OP_SECTOR_READ);
    wire cmd_rd_now = (rx_byte == OP_STATUS_READ) || (rx_byte == OP_IDENT_READ);
    assign cmd_state = cmd_addr ? ST_ADDR :
        cmd_rd_now ? ST_RDATA :
        (rx_byte == OP_STATUS_WRITE) ? ST_STAT_WR : ST_IGNORE_ALIAS;
    wire op_sector = (op_reg == OP_SECTOR_WRITE) || (op_reg == OP_SECTOR_READ);
    wire op_write = (op_reg == OP_ARRAY_WRITE) || (op_reg == OP_SECTOR_WRITE);
    wire op_fast = (op_reg == OP_FAST_READ);
    wire op_clears_wel = (op_reg == OP_WRITE_DISABLE) || (op_reg == OP_STATUS_WRITE) ||
        op_write;
    wire [1:0] rd_src = (op_reg == OP_STATUS_READ) ? SRC_STATUS :
        (op_reg == OP_IDENT_READ) ? SRC_IDENT :
        op_sector ? SRC_SECTOR : SRC_MAIN;

    // address handling: 20 low bits for the array, 8 for the sector
    wire addr_last = (abyte_reg == ADDR_BYTE_LAST);
    wire [23:0] addr_full = {ashift_reg, rx_byte};
    wire [ADDR_W-1:0] addr_step = op_sector ?
        {addr_reg[ADDR_W-1:SECT_W], addr_reg[SECT_W-1:0] + 8'h01} :
        addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};

    // block protection of the main array by the two block bits
    wire prot_hit = (bp_reg == 2'h3) ||
        ((bp_reg == 2'h2) && addr_reg[ADDR_W-1]) ||
        ((bp_reg == 2'h1) && (addr_reg[ADDR_W-1:ADDR_W-2] == 2'h3));
    wire main_block = !op_sector && prot_hit;

    // write strobes: latch sampled at frame start, halted bursts drop data
    wire wdata_byte = byte_done && (state_reg == ST_WDATA);
    wire commit_ok = frame_wel_reg && !halt_reg && !main_block;
    wire main_we = wdata_byte && commit_ok && !op_sector;
    wire sect_we = wdata_byte && commit_ok && op_sector;
    wire sr_blocked = ppe_reg && !wp_n_s;
    wire sr_write = byte_done && (state_reg == ST_STAT_WR) && frame_wel_reg && !sr_blocked;

    wire [7:0] status_w = {ppe_reg, 1'b1, 2'b00, bp_reg, wel_reg, 1'b0};
    wire [71:0] id_word = {ID_MAKER, ID_FAMILY, ID_DENSITY, ID_INRUSH, ID_SUBTYPE,
        ID_REVISION, ID_VOLTAGE, ID_FREQ};
    wire [7:0] id_byte = id_word[{id_idx_reg, 3'b000} +: 8];
    wire [7:0] tx_src = (rd_src == SRC_STATUS) ? status_w :
        (rd_src == SRC_IDENT) ? id_byte :
        (rd_src == SRC_SECTOR) ? sect_rdata : main_rdata;
    wire enter_read = (state_next == ST_RDATA) && (state_reg != ST_RDATA);
    wire rd_byte = byte_done && (state_reg == ST_RDATA);

    fce_store #(.ADDR_W(ADDR_W)) u_store (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .addr(addr_reg),
        .wdata(rx_byte),
        .main_we(main_we),
        .sect_we(sect_we),
        .main_rdata(main_rdata),
        .sect_rdata(sect_rdata)
    );

    // frame sequencer; deselect always returns to idle
    always_comb begin
        state_next = state_reg;
        if (cs_n_s) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: state_next = op_valid_reg ? ST_IDLE : ST_CMD;
                ST_CMD: if (byte_done) state_next = cmd_state;
                ST_ADDR: if (byte_done && addr_last) begin
                    state_next = op_write ? ST_WDATA : (op_fast ? ST_DUMMY : ST_RDATA);
                end
                ST_DUMMY: if (byte_done) state_next = ST_RDATA;
                ST_STAT_WR: if (byte_done) state_next = ST_IDLE;
                default: state_next = state_reg;
            endcase
        end
    end

    // edge trackers and bit framing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
            state_reg <= ST_IDLE;
            bit_reg <= 3'h0;
            sh_reg <= 7'h00;
        end else begin
            sck_prev_reg <= sck_s;
            cs_prev_reg <= cs_n_s;
            state_reg <= state_next;
            bit_reg <= cs_n_s ? 3'h0 : (sck_rise ? bit_reg + 3'h1 : bit_reg);
            sh_reg <= sck_rise ? rx_byte[6:0] : sh_reg;
        end
    end

    // opcode, frame latch snapshot and address capture
    always_ff @(posedge sys_clk) begin
        if (!rst_n || cs_n_s) begin
            op_reg <= 8'h00;
            op_valid_reg <= 1'b0;
            frame_wel_reg <= 1'b0;
            abyte_reg <= 2'h0;
            ashift_reg <= 16'h0000;
        end else if (byte_done && state_reg == ST_CMD) begin
            op_reg <= rx_byte;
            op_valid_reg <= 1'b1;
            frame_wel_reg <= wel_reg;
        end else if (byte_done && state_reg == ST_ADDR) begin
            abyte_reg <= abyte_reg + 2'h1;
            ashift_reg <= addr_full[15:0];
        end
    end

    // running address: loaded after the third byte, steps per data byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            addr_reg <= '0;
            halt_reg <= 1'b0;
            id_idx_reg <= 4'h0;
        end else if (cs_n_s) begin
            halt_reg <= 1'b0;
            id_idx_reg <= 4'h0;
        end else if (byte_done && state_reg == ST_ADDR && addr_last) begin
            addr_reg <= addr_full[ADDR_W-1:0];
        end else if (wdata_byte) begin
            halt_reg <= halt_reg || main_block;
            addr_reg <= (halt_reg || main_block) ? addr_reg : addr_step;
        end else if (rd_byte) begin
            addr_reg <= addr_step;
            id_idx_reg <= (id_idx_reg == ID_BYTE_LAST) ? 4'h0 : id_idx_reg + 4'h1;
        end
    end

    // status register bits; latch set and cleared on deselect
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wel_reg <= SR_WEL_RESET;
            ppe_reg <= SR_PPE_RESET;
            bp_reg <= SR_BP_RESET;
        end else begin
            if (sr_write) begin
                ppe_reg <= rx_byte[SR_PPE_BIT];
                bp_reg <= {rx_byte[SR_BPH_BIT], rx_byte[SR_BPL_BIT]};
            end
            if (cs_rise && op_valid_reg && op_reg == OP_WRITE_ENABLE) begin
                wel_reg <= 1'b1;
            end else if (cs_rise && op_valid_reg && op_clears_wel) begin
                wel_reg <= 1'b0;
            end
        end
    end

    // read path: fetch two cycles ahead of the next falling edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n || cs_n_s) begin
            fetch_reg <= 1'b0;
            fetch2_reg <= 1'b0;
            tx_reg <= 8'h00;
        end else begin
            fetch_reg <= enter_read || rd_byte;
            fetch2_reg <= fetch_reg;
            if (fetch2_reg) begin
                tx_reg <= tx_src;
            end else if (sck_fall && state_reg == ST_RDATA) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // output pin: driven from first data fall until deselect
    always_ff @(posedge sys_clk) begin
        if (!rst_n || cs_n_s) begin
            so_reg <= 1'b0;
            oe_reg <= 1'b0;
            status_reg <= status_w;
        end else begin
            status_reg <= status_w;
            if (sck_fall && state_reg == ST_RDATA) begin
                so_reg <= tx_reg[7];
                oe_reg <= 1'b1;
            end
        end
    end

    assign spi_so = so_reg;
    assign spi_so_oe = oe_reg;
    assign status_byte = status_reg;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_oe_off_desel: assert property (cs_n_s |=> !spi_so_oe)
        else $error("output enabled while deselected");
    a_wel_cleared: assert property (cs_rise && op_valid_reg && op_clears_wel
        |=> !wel_reg)
        else $error("write latch kept after write frame");
    a_main_commit: assert property (main_we |-> frame_wel_reg && !prot_hit)
        else $error("array written without latch or into protected range");
    a_stat_gate: assert property ((ppe_reg && !wp_n_s && state_reg == ST_STAT_WR) |=>
        $stable(bp_reg))
        else $error("status written while pin protected");
    a_fixed_bits: assert property (status_byte[6] && status_byte[5:4] == 2'b00 &&
        !status_byte[0])
        else $error("fixed status bits wrong");
    a_addr_wrap: assert property (rd_byte && !op_sector && (&addr_reg) |=>
        addr_reg == '0)
        else $error("address did not wrap");
    a_dummy_then_read: assert property (state_reg == ST_DUMMY && byte_done && !cs_n_s
        |=> state_reg == ST_RDATA)
        else $error("dummy byte not followed by data");
    a_tx_load: assert property (enter_read |-> ##2 fetch2_reg ##1 (tx_reg == $past(tx_src)
        || cs_n_s))
        else $error("read byte not loaded");
    a_halt_hold: assert property (wdata_byte && main_block |=> halt_reg &&
        $stable(addr_reg))
        else $error("burst continued into protected range");
    // a halted burst must never reach the array, even if the address moved on
    a_halt_drop: assert property (halt_reg |-> !main_we)
        else $error("array written after burst halted");
    a_bit_wrap: assert property (byte_done |=> bit_reg == 3'h0)
        else $error("bit counter did not restart after eight bits");
    a_sect_wrap: assert property (rd_byte && op_sector && addr_reg[SECT_W-1:0] == 8'hFF
        |=> addr_reg[SECT_W-1:0] == 8'h00)
        else $error("sector address did not wrap within the sector");
    a_oe_on_read: assert property (sck_fall && state_reg == ST_RDATA |=> spi_so_oe)
        else $error("output not driven during read data");
    a_wel_set: assert property (cs_rise && op_valid_reg && op_reg == OP_WRITE_ENABLE
        |=> wel_reg)
        else $error("write enable frame did not set the latch");

    c_array_read: cover property (state_reg == ST_RDATA && op_reg == OP_ARRAY_READ);
    c_fast_read: cover property (state_reg == ST_DUMMY ##[1:300] state_reg == ST_RDATA);
    c_array_write: cover property (main_we);
    c_status_write: cover property (sr_write);
    c_ident_read: cover property (rd_byte && op_reg == OP_IDENT_READ);
endmodule

// [src/fce_pkg.sv]
// Purpose: shared constants and types of the serial memory command engine
// Assumes: spi modes 0 and 3, msb first, sampled on the system clock
// Notes: opcodes, status layout, reset values and state codes live here
//
// Contract
// - status read opcode returns status byte
// - status write updates protect-pin enable, block bits
// - status write clears write enable latch
// - protect pin gates only status writes
// - three address bytes, low 20 bits used
// - address increments per byte, wraps to zero
// - eight clocks per byte, msb first
// - byte committed on eighth bit, partial dropped
// - protected address halts burst, data ignored
// - read drives data, serial input ignored
// - chip select rise ends read, output off
// - fast read adds one dummy byte
// - fast read ignores input, ends on deselect
// - sector write uses low 8 address bits
// - sector read outputs sequential sector bytes
// - sector read ends, output off on deselect
// - ident read sends nine bytes, lsb first
// - identifier field layout over 72 bits
// - deselect after write frames clears latch
// - block bits protect none, quarter, half, all
// - status write blocked when enable set, pin low
// - status bit layout with fixed bits
package fce_pkg;
    // opcodes
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_SECTOR_WRITE = 8'h42;
    localparam logic [7:0] OP_SECTOR_READ = 8'h4B;
    localparam logic [7:0] OP_IDENT_READ = 8'h9F;
    // status register field positions
    localparam int SR_PPE_BIT = 7;
    localparam int SR_BPH_BIT = 3;
    localparam int SR_BPL_BIT = 2;
    // status register reset values
    localparam logic SR_PPE_RESET = 1'b0;
    localparam logic [1:0] SR_BP_RESET = 2'h0;
    localparam logic SR_WEL_RESET = 1'b0;
    // counts
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;
    localparam logic [3:0] ID_BYTE_LAST = 4'h8;
    localparam int ADDR_W_DEFAULT = 20;
    localparam int SECT_W = 8;
    // read data sources
    localparam logic [1:0] SRC_MAIN = 2'h0;
    localparam logic [1:0] SRC_SECTOR = 2'h1;
    localparam logic [1:0] SRC_STATUS = 2'h2;
    localparam logic [1:0] SRC_IDENT = 2'h3;
    // frame sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CMD = 7'h02,
        ST_ADDR = 7'h04,
        ST_DUMMY = 7'h08,
        ST_WDATA = 7'h10,
        ST_RDATA = 7'h20,
        ST_STAT_WR = 7'h40
    } fce_state_t;
    // a frame with an unknown or finished command just waits for deselect
    localparam fce_state_t ST_IGNORE_ALIAS = ST_IDLE;
endpackage

// [src/fce_sync.sv]
// Purpose: two-stage synchroniser for the serial pins
// Assumes: inputs are asynchronous to sys_clk
// Notes: only the second stage leaves this module
`timescale 1ns/100ps
module fce_sync
    import fce_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic hold_reg;
            // first stage feeds the second and nothing else
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    meta_reg <= RESET_VAL[i];
                    hold_reg <= RESET_VAL[i];
                end else begin
                    meta_reg <= async_in[i];
                    hold_reg <= meta_reg;
                end
            end
            assign sync_out[i] = hold_reg;
        end
    endgenerate
endmodule

// [src/fce_store.sv]
// Purpose: main array and special sector storage
// Assumes: one byte write per cycle, registered read
// Notes: no reset on the arrays, contents are nonvolatile in intent
`timescale 1ns/100ps
module fce_store
    import fce_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic main_we,
    input wire logic sect_we,
    output logic [7:0] main_rdata,
    output logic [7:0] sect_rdata
);
    logic [7:0] main_mem [0:(1<<ADDR_W)-1];
    logic [7:0] sect_mem [0:(1<<SECT_W)-1];
    logic [7:0] main_rd_reg;
    logic [7:0] sect_rd_reg;

    // sector is indexed by the low address byte only
    always_ff @(posedge sys_clk) begin
        if (main_we) begin
            main_mem[addr] <= wdata;
        end
        if (sect_we) begin
            sect_mem[addr[SECT_W-1:0]] <= wdata;
        end
    end

    // read one cycle after the address settles
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            main_rd_reg <= 8'h00;
            sect_rd_reg <= 8'h00;
        end else begin
            main_rd_reg <= main_mem[addr];
            sect_rd_reg <= sect_mem[addr[SECT_W-1:0]];
        end
    end

    assign main_rdata = main_rd_reg;
    assign sect_rdata = sect_rd_reg;
endmodule

// [tb/fce_master_model.sv]
// Purpose: behavioural spi bus master that drives frames into the command engine
// Assumes: mode 0, sck idle low, 200 ns period, edges just after a sys_clk rise
// Notes: sck stands still between frames; si toggles on release so no stale bit lingers
`timescale 1ns/100ps
module fce_master_model (
    input wire logic sys_clk,
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_si,
    input wire logic spi_so
);
    // idle bus at time zero
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_si = 1'b0;
    end
    // open a frame; the bench sends write enable in a frame of its own
    task automatic start();
        @(posedge sys_clk);
        #1 spi_cs_n = 1'b0;
        #100;
    endtask
    // deselect ends every frame, gap kept far above four cycles
    task automatic stop();
        #100 spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        #200;
    endtask
    // n bits msb first; so sampled late in the high phase, after it has settled
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            spi_si = tx[i];
            #100 spi_sck = 1'b1;
            #90 rx[i] = spi_so;
            #10 spi_sck = 1'b0;
        end
    endtask
endmodule

// [tb/tb.sv]
// Purpose: self-checking bench of the serial memory command engine
// Assumes: partner master model drives every frame, 40 MHz system clock
// Notes: reference model keeps array, sector and status in plain variables
`timescale 1ns/100ps
module tb;
    import fce_pkg::*;
    localparam logic [55:0] MAKER = 56'h12_3456_789A_BCDE; // arbitrary value
    localparam logic [15:0] PROD = 16'h5A6B; // arbitrary value
    localparam logic [71:0] ID = {MAKER, PROD};
    logic sys_clk, rst_n, wp_n, spi_so, spi_so_oe, ppe, write_enable_latch;
    logic [7:0] status_byte, rx, seed;
    logic [1:0] bp;
    logic [7:0] mem [int];
    logic [7:0] sect [int];
    int n_mismatch, cmp_count;
    wire spi_cs_n, spi_sck, spi_si;
    // released so line floats so a stale bit cannot pass
    wire so_line = spi_so_oe ? spi_so : 1'bz;
    fce_engine #(.ID_MAKER(MAKER), .ID_FAMILY(PROD[15:13]), .ID_DENSITY(PROD[12:9]),
        .ID_INRUSH(PROD[8]), .ID_SUBTYPE(PROD[7:5]), .ID_REVISION(PROD[4:3]),
        .ID_VOLTAGE(PROD[2]), .ID_FREQ(PROD[1:0])) fce_engine_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
        .wp_n(wp_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .status_byte(status_byte));
    fce_master_model fce_master_model_i (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(so_line));
    // free running system clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // lfsr gives the data bytes and the junk driven on si during reads
    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction
    function automatic logic guarded(input int a);
        return bp == 2'h3 || (bp == 2'h2 && a >= 32'h0008_0000) || (bp == 2'h1 && a >= 32'h000C_0000);
    endfunction
    function automatic logic [7:0] sr();
        return {ppe, 1'b1, 2'h0, bp, write_enable_latch, 1'b0};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t output enable got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic head(input logic [7:0] op, input logic [23:0] a);
        fce_master_model_i.start();
        fce_master_model_i.xfer(op, 8, rx);
        for (int i = 2; i >= 0; i--) fce_master_model_i.xfer(a[i * 8 +: 8], 8, rx);
    endtask
    task automatic write_enable_cmd();
        fce_master_model_i.start();
        fce_master_model_i.xfer(OP_WRITE_ENABLE, 8, rx);
        fce_master_model_i.stop();
        write_enable_latch = 1'b1;
    endtask
    // model of a write burst: freezes at the first guarded address, drops partial tail
    task automatic wr(input logic [7:0] op, input logic [23:0] a, input int n, input int tail);
        logic sec;
        logic live;
        int p;
        logic [7:0] d;
        sec = (op == OP_SECTOR_WRITE);
        live = write_enable_latch;
        p = sec ? a[7:0] : a[19:0];
        head(op, a);
        for (int k = 0; k < n; k++) begin
            d = rnd();
            fce_master_model_i.xfer(d, 8, rx);
            if (live && !sec && guarded(p)) live = 1'b0;
            if (live && sec) sect[p] = d;
            if (live && !sec) mem[p] = d;
            p = sec ? (p + 1) % 256 : (p + 1) % 32'h0010_0000;
        end
        if (tail > 0) fce_master_model_i.xfer(rnd(), tail, rx);
        fce_master_model_i.stop();
        write_enable_latch = 1'b0;
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
        int p;
        p = (op == OP_SECTOR_READ) ? a[7:0] : a[19:0];
        head(op, a);
        if (op == OP_FAST_READ) fce_master_model_i.xfer(8'h00, 8, rx);
        for (int k = 0; k < n; k++) begin
            fce_master_model_i.xfer(rnd(), 8, rx);
            cmp(rx, (op == OP_SECTOR_READ) ? sect[p] : mem[p]);
            cmp1(spi_so_oe, 1'b1);
            p = (op == OP_SECTOR_READ) ? (p + 1) % 256 : (p + 1) % 32'h0010_0000;
        end
        fce_master_model_i.stop();
        cmp1(spi_so_oe, 1'b0);
    endtask
    task automatic peek(input logic [7:0] op, input int n);
        fce_master_model_i.start();
        fce_master_model_i.xfer(op, 8, rx);
        for (int k = 0; k < n; k++) begin
            fce_master_model_i.xfer(rnd(), 8, rx);
            cmp(rx, (op == OP_IDENT_READ) ? ID[(k % 9) * 8 +: 8] : sr());
        end
        fce_master_model_i.stop();
        cmp(status_byte, sr());
    endtask
    // status write model: blocked only with enable set and pin low
    task automatic swr(input logic [7:0] d);
        write_enable_cmd();
        fce_master_model_i.start();
        fce_master_model_i.xfer(OP_STATUS_WRITE, 8, rx);
        fce_master_model_i.xfer(d, 8, rx);
        fce_master_model_i.stop();
        if (!(ppe && !wp_n)) begin
            ppe = d[7];
            bp = d[3:2];
        end
        write_enable_latch = 1'b0;
        peek(OP_STATUS_READ, 2);
    endtask
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run of some 250 us
    initial begin
        #1_000_000;
        n_mismatch++;
        test_done();
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        seed = 8'h4F;
        {ppe, bp, write_enable_latch} = 4'h0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        cmp(status_byte, 8'h40);
        cmp1(spi_so_oe, 1'b0);
        write_enable_cmd();
        wr(OP_ARRAY_WRITE, 24'hFB_FFFE, 6, 0);
        peek(OP_STATUS_READ, 2);
        wr(OP_ARRAY_WRITE, 24'h0B_FFFE, 3, 0);
        write_enable_cmd();
        wr(OP_ARRAY_WRITE, 24'h30_0000, 4, 0);
        write_enable_cmd();
        wr(OP_ARRAY_WRITE, 24'hAF_FFFE, 3, 5);
        rd(OP_ARRAY_READ, 24'h5F_FFFE, 6);
        rd(OP_FAST_READ, 24'h0B_FFFE, 6);
        swr(8'hB5);
        @(posedge sys_clk);
        #1 wp_n = 1'b0;
        write_enable_cmd();
        wr(OP_ARRAY_WRITE, 24'h0B_FFFE, 6, 0);
        rd(OP_ARRAY_READ, 24'h0B_FFFE, 6);
        swr(8'h00);
        @(posedge sys_clk);
        #1 wp_n = 1'b1;
        swr(8'h00);
        wr(OP_SECTOR_WRITE, 24'h00_0010, 2, 0);
        write_enable_cmd();
        wr(OP_SECTOR_WRITE, 24'hAB_CDFE, 2, 0);
        write_enable_cmd();
        wr(OP_SECTOR_WRITE, 24'h00_0010, 2, 0);
        rd(OP_SECTOR_READ, 24'h12_34FE, 2);
        rd(OP_SECTOR_READ, 24'h00_0010, 2);
        peek(OP_IDENT_READ, 10);
        test_done();
    end
endmodule
